// *** core/adccal_pkg.sv ***
package adccal_pkg;
    // Widths
    localparam int FILT_W = 24;
    localparam int CODE_W = 20;
    localparam int GAIN_W = 24;
    localparam int GAIN_SH = 16;
    localparam int DIV_STEPS = CODE_W + GAIN_SH + 1;

    // Master clock figures
    localparam int MCLK_HZ = 50000000;
    localparam int CAL_CYCLES = 3246;
    localparam logic [11:0] CAL_LAST = 12'(CAL_CYCLES - 1);
    localparam logic [11:0] OFFSET_END = 12'(CAL_CYCLES / 2 - 1);
    localparam logic [11:0] GAIN_END = 12'(CAL_CYCLES - 1 - DIV_STEPS - 2);

    // Codes
    localparam logic [19:0] MID_WIDE = 20'h80000;
    localparam logic [15:0] MID_NARROW = 16'h8000;
    localparam logic [19:0] FULL_WIDE = 20'hFFFFF;

    // Register byte addresses
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_ZERO = 8'h08;
    localparam logic [7:0] REG_GAIN = 8'h0C;
    localparam logic [7:0] REG_RESULT = 8'h10;

    // Values after reset
    localparam logic CTRL_WIDE_RST = 1'b1;
    localparam logic [GAIN_W-1:0] GAIN_RST = 24'h010000;
    localparam logic [FILT_W-1:0] ZERO_RST = 24'h000000;

    // Modulator input routing
    typedef enum logic [1:0] {
        MOD_ANALOG = 2'b00,
        MOD_ZERO = 2'b01,
        MOD_FULL = 2'b10
    } adccal_mod_e;

    typedef enum logic [2:0] {
        ST_STANDBY = 3'b000,
        ST_CAL_OFFSET = 3'b001,
        ST_CAL_GAIN = 3'b010,
        ST_CAL_DIV = 3'b011,
        ST_CONVERT = 3'b100
    } adccal_state_e;

    typedef struct packed {
        logic valid;
        logic [FILT_W-1:0] data;
    } adccal_filt_s;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wrData;
        logic wr;
        logic rd;
    } adccal_bus_s;
endpackage

// *** core/adccal_core.sv ***
// Notes on behaviour
// - Unipolar results are straight binary, bipolar results offset binary.
// - Result code is 16 bits (narrow) or 20 bits (wide) in both modes.
// - Offset step routes both modulator inputs to negative reference, stores zero code.
// - Gain step routes inputs across references; gain factor derived with zero code.
// - Gain factor and zero code are held and applied to every conversion.
// - Channel and polarity selects are ignored while calibrating; controller keeps them steady.
// - One coefficient set serves both unipolar and bipolar modes.
// - Bipolar adds 8000H or 80000H midscale and doubles the code step.
// - Bipolar slope calibrated zero to positive full scale, extended below zero.
// - Switching polarity needs no recalibration.
// - Calibration can be requested any time and replaces stored coefficients.
// - Sampling switch alternates buffer and input pin every master clock cycle.
// - Calibration starts when calibrate and convert requests are both high.
// - A full calibration takes 3246 master clock cycles.
`timescale 1ns/1ps
`default_nettype none
module adccal_core (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic calRequest,
    input wire logic convertRequest,
    input wire logic polaritySelect,
    input wire logic channelSelectLsb,
    input wire logic channelSelectMsb,
    input wire adccal_pkg::adccal_filt_s filtIn,
    input wire adccal_pkg::adccal_bus_s busIn,
    output logic [31:0] rdData_ff,
    output logic [1:0] modInSel_ff,
    output logic sampSwitch_ff,
    output logic [1:0] chanSel_ff,
    output logic calBusy_ff,
    output logic [19:0] resultCode_ff,
    output logic resultValid_ff
);
    // Sequencer and calibration window
    adccal_pkg::adccal_state_e state_ff, nxt_state;
    logic [11:0] calCnt_ff;

    // Request history for edge detection
    logic calCmdPrev_ff;
    logic convPrev_ff;

    // Software-visible control and status
    logic ctrlWide_ff;
    logic calValid_ff;

    // Stored coefficients and the raw full-scale word
    logic [adccal_pkg::FILT_W-1:0] zero_ff;
    logic [adccal_pkg::FILT_W-1:0] full_ff;
    logic [adccal_pkg::GAIN_W-1:0] gain_ff;

    // Serial divider working set
    logic [adccal_pkg::FILT_W:0] rem_ff;
    logic [adccal_pkg::DIV_STEPS-1:0] quo_ff;
    logic [5:0] divCnt_ff;

    // Command decode; the rising edge of the joint request restarts calibration
    wire calCmd = calRequest & convertRequest;
    wire calStart = calCmd & ~calCmdPrev_ff;
    wire convRise = convertRequest & ~convPrev_ff;
    wire calibrating = (state_ff == adccal_pkg::ST_CAL_OFFSET) || (state_ff == adccal_pkg::ST_CAL_GAIN) ||
        (state_ff == adccal_pkg::ST_CAL_DIV);

    // Phase ends of the calibration window, all taken from the one counter
    wire offsetDone = (state_ff == adccal_pkg::ST_CAL_OFFSET) && (calCnt_ff == adccal_pkg::OFFSET_END);
    wire gainDone = (state_ff == adccal_pkg::ST_CAL_GAIN) && (calCnt_ff == adccal_pkg::GAIN_END);
    wire calDone = (state_ff == adccal_pkg::ST_CAL_DIV) && (calCnt_ff == adccal_pkg::CAL_LAST);

    // Restoring divider step: gain = 2^36 / span, span forced nonzero
    wire [adccal_pkg::FILT_W-1:0] spanRaw = full_ff - zero_ff;
    wire spanBad = (full_ff <= zero_ff);
    wire [adccal_pkg::FILT_W:0] span = spanBad ? 25'h0000001 : {1'b0, spanRaw};
    wire dividendBit = (divCnt_ff == 6'h00);
    wire [adccal_pkg::FILT_W:0] remShift = {rem_ff[adccal_pkg::FILT_W-1:0], dividendBit};
    wire remGe = (remShift >= span);
    wire [adccal_pkg::FILT_W:0] remNext = remGe ? (remShift - span) : remShift;
    wire divRun = (state_ff == adccal_pkg::ST_CAL_DIV) && (divCnt_ff < 6'(adccal_pkg::DIV_STEPS));
    wire quoOver = |quo_ff[adccal_pkg::DIV_STEPS-1:adccal_pkg::GAIN_W];
    wire [adccal_pkg::GAIN_W-1:0] gainNew = quoOver ? 24'hFFFFFF : quo_ff[adccal_pkg::GAIN_W-1:0];

    // Scaling: same zero and gain for both polarities; bipolar halves the gain for a doubled step
    wire signed [adccal_pkg::FILT_W:0] diff = $signed({1'b0, filtIn.data}) - $signed({1'b0, zero_ff});
    wire signed [49:0] prod = diff * $signed({1'b0, gain_ff});
    wire signed [49:0] uniCode = prod >>> adccal_pkg::GAIN_SH;
    wire signed [49:0] bipCode = (prod >>> (adccal_pkg::GAIN_SH + 1)) + $signed({30'h0, adccal_pkg::MID_WIDE});
    wire signed [49:0] selCode = polaritySelect ? bipCode : uniCode;

    // Clamp rather than wrap, so an overrange input never reads as a small code
    wire satLow = selCode < 0;
    wire satHigh = selCode > $signed({30'h0, adccal_pkg::FULL_WIDE});
    wire [19:0] wideCode = satLow ? 20'h00000 : (satHigh ? adccal_pkg::FULL_WIDE : selCode[19:0]);
    wire [19:0] outCode = ctrlWide_ff ? wideCode : {4'h0, wideCode[19:4]};

    // Only words that arrive in the convert state become results
    wire convTake = filtIn.valid && (state_ff == adccal_pkg::ST_CONVERT);

    // Register decode
    wire [31:0] statusWord = {24'h0, 3'h0, calValid_ff, calBusy_ff, state_ff};
    wire [31:0] rdMux = (busIn.addr == adccal_pkg::REG_CTRL) ? {31'h0, ctrlWide_ff} :
        (busIn.addr == adccal_pkg::REG_STATUS) ? statusWord :
        (busIn.addr == adccal_pkg::REG_ZERO) ? {8'h00, zero_ff} :
        (busIn.addr == adccal_pkg::REG_GAIN) ? {8'h00, gain_ff} :
        (busIn.addr == adccal_pkg::REG_RESULT) ? {12'h000, resultCode_ff} : 32'h0;

    // Modulator routing, decoded from the next state so it switches with the phase
    wire [1:0] nxt_modSel = (nxt_state == adccal_pkg::ST_CAL_OFFSET) ? adccal_pkg::MOD_ZERO :
        ((nxt_state == adccal_pkg::ST_CAL_GAIN) || (nxt_state == adccal_pkg::ST_CAL_DIV)) ?
        adccal_pkg::MOD_FULL : adccal_pkg::MOD_ANALOG;

    // Sequencer next state
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            adccal_pkg::ST_STANDBY: begin
                if (convRise) begin
                    nxt_state = adccal_pkg::ST_CONVERT;
                end
            end
            adccal_pkg::ST_CAL_OFFSET: begin
                if (offsetDone) begin
                    nxt_state = adccal_pkg::ST_CAL_GAIN;
                end
            end
            adccal_pkg::ST_CAL_GAIN: begin
                if (gainDone) begin
                    nxt_state = adccal_pkg::ST_CAL_DIV;
                end
            end
            adccal_pkg::ST_CAL_DIV: begin
                if (calDone) begin
                    nxt_state = convertRequest ? adccal_pkg::ST_CONVERT : adccal_pkg::ST_STANDBY;
                end
            end
            adccal_pkg::ST_CONVERT: begin
                if (!convertRequest && filtIn.valid) begin
                    nxt_state = adccal_pkg::ST_STANDBY;
                end
            end
            default: begin
                nxt_state = adccal_pkg::ST_STANDBY;
            end
        endcase
        if (calStart) begin
            nxt_state = adccal_pkg::ST_CAL_OFFSET;
        end
    end

    // Sequencer state
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            state_ff <= adccal_pkg::ST_STANDBY;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Calibration cycle count; a restart zeroes it so every window is a full one
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            calCnt_ff <= 12'h000;
        end else begin
            calCnt_ff <= (calStart || !calibrating) ? 12'h000 : calCnt_ff + 12'h001;
        end
    end

    // Request history; low after reset, the idle level of both pins, so no false edge
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            calCmdPrev_ff <= 1'b0;
            convPrev_ff <= 1'b0;
        end else begin
            calCmdPrev_ff <= calCmd;
            convPrev_ff <= convertRequest;
        end
    end

    // Busy and routing follow the next state so they line up with it
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            calBusy_ff <= 1'b0;
            modInSel_ff <= adccal_pkg::MOD_ANALOG;
        end else begin
            calBusy_ff <= (nxt_state == adccal_pkg::ST_CAL_OFFSET) || (nxt_state == adccal_pkg::ST_CAL_GAIN) ||
                (nxt_state == adccal_pkg::ST_CAL_DIV);
            modInSel_ff <= nxt_modSel;
        end
    end

    // Sampling switch phase flips every edge; one clock edge stands for one half period
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            sampSwitch_ff <= 1'b0;
        end else begin
            sampSwitch_ff <= ~sampSwitch_ff;
        end
    end

    // Channel latched on convert rise, never while calibrating
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            chanSel_ff <= 2'b00;
        end else if (convRise && !calibrating && !calCmd) begin
            chanSel_ff <= {channelSelectMsb, channelSelectLsb};
        end
    end

    // Zero code: the last ones density seen with both inputs on the negative reference
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            zero_ff <= adccal_pkg::ZERO_RST;
        end else if (state_ff == adccal_pkg::ST_CAL_OFFSET && filtIn.valid) begin
            zero_ff <= filtIn.data;
        end
    end

    // Full-scale word: the last ones density seen across the two references
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            full_ff <= adccal_pkg::ZERO_RST;
        end else if (state_ff == adccal_pkg::ST_CAL_GAIN && filtIn.valid) begin
            full_ff <= filtIn.data;
        end
    end

    // Gain factor is replaced only once the divider has finished
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            gain_ff <= adccal_pkg::GAIN_RST;
        end else if (calDone) begin
            gain_ff <= gainNew;
        end
    end

    // Coefficients-valid flag; a finish in the restart cycle still counts as set
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            calValid_ff <= 1'b0;
        end else if (calDone) begin
            calValid_ff <= 1'b1;
        end else if (calStart) begin
            calValid_ff <= 1'b0;
        end
    end

    // Divider remainder; one quotient bit per clock in the tail of the window
    always_ff @(posedge mclk) begin
        if (!nrst || state_ff != adccal_pkg::ST_CAL_DIV) begin
            rem_ff <= '0;
        end else if (divRun) begin
            rem_ff <= remNext;
        end
    end

    // Quotient shifts in from the bottom, most significant bit first
    always_ff @(posedge mclk) begin
        if (!nrst || state_ff != adccal_pkg::ST_CAL_DIV) begin
            quo_ff <= '0;
        end else if (divRun) begin
            quo_ff <= {quo_ff[adccal_pkg::DIV_STEPS-2:0], remGe};
        end
    end

    // Step count; the divider is slow but costs no multiplier-sized array
    always_ff @(posedge mclk) begin
        if (!nrst || state_ff != adccal_pkg::ST_CAL_DIV) begin
            divCnt_ff <= 6'h00;
        end else if (divRun) begin
            divCnt_ff <= divCnt_ff + 6'h01;
        end
    end

    // Result strobe, one cycle per accepted word
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            resultValid_ff <= 1'b0;
        end else begin
            resultValid_ff <= convTake;
        end
    end

    // Result code holds between words; calibration words never reach it
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            resultCode_ff <= 20'h00000;
        end else if (convTake) begin
            resultCode_ff <= outCode;
        end
    end

    // Control register, the only writable location
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            ctrlWide_ff <= adccal_pkg::CTRL_WIDE_RST;
        end else if (busIn.wr && busIn.addr == adccal_pkg::REG_CTRL) begin
            ctrlWide_ff <= busIn.wrData[0];
        end
    end

    // Read data stands for one cycle and is zero otherwise
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            rdData_ff <= 32'h0;
        end else begin
            rdData_ff <= busIn.rd ? rdMux : 32'h0;
        end
    end
endmodule
`default_nettype wire

// *** verif/adccal_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
module adccal_sva (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic calRequest,
    input wire logic convertRequest,
    input wire adccal_pkg::adccal_filt_s filtIn,
    input wire adccal_pkg::adccal_bus_s busIn,
    input wire logic [31:0] rdData_ff,
    input wire logic [1:0] modInSel_ff,
    input wire logic sampSwitch_ff,
    input wire logic [1:0] chanSel_ff,
    input wire logic calBusy_ff,
    input wire logic resultValid_ff
);
    logic [12:0] busyCnt_ff;
    // Busy length; a restarted calibration would keep counting, so restarts are not exercised
    always_ff @(posedge mclk) begin
        busyCnt_ff <= (nrst && calBusy_ff) ? busyCnt_ff + 13'h1 : 13'h0;
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    property p_calStart;
        $rose(calRequest && convertRequest) |=> calBusy_ff && modInSel_ff == 2'b01;
    endproperty
    a_calStart: assert property (p_calStart) else $error("calibration did not start");
    property p_calLen;
        $fell(calBusy_ff) |-> busyCnt_ff == 13'hCAE;
    endproperty
    a_calLen: assert property (p_calLen) else $error("calibration length off");
    property p_gainStep;
        calBusy_ff && modInSel_ff == 2'b10 && $past(modInSel_ff) == 2'b01 |-> busyCnt_ff == 13'h657;
    endproperty
    a_gainStep: assert property (p_gainStep) else $error("gain step began at wrong count");
    property p_idleRoute;
        !calBusy_ff |-> modInSel_ff == 2'b00;
    endproperty
    a_idleRoute: assert property (p_idleRoute) else $error("references routed outside calibration");
    property p_switch;
        $past(nrst) |-> sampSwitch_ff != $past(sampSwitch_ff);
    endproperty
    a_switch: assert property (p_switch) else $error("sample switch did not alternate");
    property p_chanHold;
        calBusy_ff && $past(calBusy_ff) |-> $stable(chanSel_ff);
    endproperty
    a_chanHold: assert property (p_chanHold) else $error("channel changed in calibration");
    property p_resultCause;
        resultValid_ff |-> $past(filtIn.valid) && !$past(calBusy_ff);
    endproperty
    a_resultCause: assert property (p_resultCause) else $error("result without a converted word");
    property p_rdIdle;
        !$past(busIn.rd) |-> rdData_ff == 32'h0;
    endproperty
    a_rdIdle: assert property (p_rdIdle) else $error("read data outside read slot");
    property p_unmapped;
        $past(busIn.rd) && $past(busIn.addr) > 8'h10 |-> rdData_ff == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule
bind adccal_core adccal_sva chk_u (.mclk(mclk), .nrst(nrst), .calRequest(calRequest),
    .convertRequest(convertRequest), .filtIn(filtIn), .busIn(busIn), .rdData_ff(rdData_ff),
    .modInSel_ff(modInSel_ff), .sampSwitch_ff(sampSwitch_ff), .chanSel_ff(chanSel_ff),
    .calBusy_ff(calBusy_ff), .resultValid_ff(resultValid_ff));
`default_nettype wire

// *** verif/adccal_filt_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module adccal_filt_model #(
    parameter logic [23:0] ZERO_LVL = 24'h200000,
    parameter logic [23:0] FULL_LVL = 24'h280000
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [1:0] modInSel,
    input wire logic [23:0] analogLvl,
    output var adccal_pkg::adccal_filt_s filtOut
);
    logic [5:0] tick_ff;
    logic wordDue;
    logic [23:0] level;
    // Reference routing decides what the modulator measures
    assign level = (modInSel == 2'b01) ? ZERO_LVL : (modInSel == 2'b10) ? FULL_LVL : analogLvl;
    // One word every 64 clocks; data churns between words so nothing stale looks valid
    always_ff @(posedge mclk) begin
        tick_ff <= nrst ? tick_ff + 6'h1 : 6'h0;
    end
    assign wordDue = (tick_ff == 6'h3F);
    assign filtOut = {wordDue, wordDue ? level : {4{tick_ff}}};
endmodule
`default_nettype wire

// *** verif/adccal_core_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module adccal_core_test;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic calRequest = 1'b0;
    logic convertRequest = 1'b0;
    logic polaritySelect = 1'b0;
    logic channelSelectLsb = 1'b0;
    logic channelSelectMsb = 1'b0;
    logic [23:0] analogLvl = 24'h200000;
    adccal_pkg::adccal_filt_s filtIn;
    adccal_pkg::adccal_bus_s busIn = '0;
    logic [31:0] rdData_ff;
    logic [1:0] modInSel_ff;
    logic [1:0] chanSel_ff;
    logic calBusy_ff;
    logic [19:0] resultCode_ff;
    logic resultValid_ff;
    int nFail = 0;
    int checkCount = 0;
    // Polarity, level, expected wide code; gain comes out as two codes per filter step
    logic [44:0] convTab [8] = '{{1'b0, 24'h200100, 20'h00200}, {1'b0, 24'h400000, 20'hFFFFF},
        {1'b0, 24'h100000, 20'h00000}, {1'b1, 24'h200100, 20'h80100}, {1'b1, 24'h1FFF00, 20'h7FF00},
        {1'b1, 24'h400000, 20'hFFFFF}, {1'b1, 24'h100000, 20'h00000}, {1'b0, 24'h200100, 20'h00200}};
    always #10 mclk = ~mclk;
    adccal_core dut_u (.mclk(mclk), .nrst(nrst), .calRequest(calRequest), .convertRequest(convertRequest),
        .polaritySelect(polaritySelect), .channelSelectLsb(channelSelectLsb),
        .channelSelectMsb(channelSelectMsb), .filtIn(filtIn), .busIn(busIn), .rdData_ff(rdData_ff),
        .modInSel_ff(modInSel_ff), .sampSwitch_ff(), .chanSel_ff(chanSel_ff), .calBusy_ff(calBusy_ff),
        .resultCode_ff(resultCode_ff), .resultValid_ff(resultValid_ff));
    adccal_filt_model model_u (.mclk(mclk), .nrst(nrst), .modInSel(modInSel_ff), .analogLvl(analogLvl),
        .filtOut(filtIn));
    // Comparison and bus helpers
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checkCount++;
        if (seen !== exp) begin
            nFail++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic regWrite(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        busIn <= '{addr: a, wrData: d, wr: 1'b1, rd: 1'b0};
        @(posedge mclk);
        busIn.wr <= 1'b0;
    endtask
    task automatic regRead(input logic [7:0] a, input logic [31:0] exp);
        @(posedge mclk);
        busIn <= '{addr: a, wrData: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge mclk);
        busIn.rd <= 1'b0;
        #1 check(rdData_ff, exp);
    endtask
    task automatic waitResult;
        int i;
        for (i = 0; i < 200; i++) begin
            @(posedge mclk);
            #1;
            if (resultValid_ff === 1'b1) break;
        end
        if (i == 200) check(32'h0, 32'h1);
    endtask
    // Inputs change right after a result, so the next word is taken with them
    task automatic convert(input logic pol, input logic [23:0] lvl, input logic [19:0] exp);
        waitResult();
        @(posedge mclk);
        polaritySelect <= pol;
        analogLvl <= lvl;
        waitResult();
        check({12'h0, resultCode_ff}, {12'h0, exp});
    endtask
    task automatic endOfTest;
        $display("checks %0d, failures %0d", checkCount, nFail);
        if (nFail == 0 && checkCount > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (20) @(posedge mclk);
        nrst <= 1'b1;
        regRead(adccal_pkg::REG_CTRL, 32'h1);
        regRead(adccal_pkg::REG_GAIN, 32'h10000);
        regRead(adccal_pkg::REG_ZERO, 32'h0);
        regRead(8'h20, 32'h0);
        @(posedge mclk);
        calRequest <= 1'b1;
        convertRequest <= 1'b1;
        repeat (5) @(posedge mclk);
        calRequest <= 1'b0;
        polaritySelect <= 1'b1;
        channelSelectLsb <= 1'b1;
        repeat (3241) @(posedge mclk);
        #1 check({31'h0, calBusy_ff}, 32'h1);
        @(posedge mclk);
        #1 check({31'h0, calBusy_ff}, 32'h0);
        check({30'h0, chanSel_ff}, 32'h0);
        regRead(adccal_pkg::REG_ZERO, 32'h200000);
        regRead(adccal_pkg::REG_GAIN, 32'h20000);
        regRead(adccal_pkg::REG_STATUS, 32'h14);
        foreach (convTab[k]) convert(convTab[k][44], convTab[k][43:20], convTab[k][19:0]);
        regRead(adccal_pkg::REG_RESULT, 32'h200);
        regWrite(adccal_pkg::REG_CTRL, 32'h0);
        convert(1'b0, 24'h200100, 20'h00020);
        convert(1'b1, 24'h200100, 20'h08010);
        // A fresh convert rise outside calibration must latch the channel
        @(posedge mclk);
        convertRequest <= 1'b0;
        channelSelectMsb <= 1'b1;
        repeat (2) @(posedge mclk);
        convertRequest <= 1'b1;
        repeat (2) @(posedge mclk);
        #1 check({30'h0, chanSel_ff}, 32'h3);
        endOfTest();
    end
    // Watchdog well beyond the expected run of about 5000 clocks
    initial begin
        #400000;
        nFail++;
        endOfTest();
    end
endmodule
`default_nettype wire
